/* hdl/cai_unit.sv */
// Purpose: alarm, charge shaping, activity and interrupt logic with serial register access
// Assumes: measurement and event inputs are on core_clk_i; scl/sda come from pins
// Notes:   mask bits gate the pin only, flags latch regardless of mask
`timescale 1ns/1ps

module cai_unit
(
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    output logic                      int_o,
    output logic                      int_oe_o,
    input  wire cai_pkg::cai_meas_s   meas_i,
    input  wire cai_pkg::cai_limits_s limits_i,
    input  wire logic                 resume_gauge_i,
    input  wire logic                 stall_expire_i,
    input  wire logic                 pack_link_error_i,
    input  wire logic                 periodic_pulse_i,
    input  wire logic [3:0]           misc_event_i,
    output logic [7:0]                user_filtered_charge_o,
    output logic [1:0]                gauge_activity_o,
    output logic                      slow_rate_o,
    output logic                      discharging_o,
    output logic                      hibernate_o
);
    import cai_pkg::*;

    typedef struct packed {
        logic        scl_s1, scl_s2, scl_s3;
        logic        sda_s1, sda_s2, sda_s3;
        cai_bus_e    st;
        logic [3:0]  cnt;
        logic [7:0]  shift;
        logic [7:0]  tx;
        logic [7:0]  ptr;
        logic        rw;
        logic        nack;
        logic        sda_oe;
        logic        sda_out;
        logic        int_oe;
        logic        int_out;
        logic [15:0] flags;
        logic [15:0] mask;
        logic        uv, ot, ut, low, high, zero;
        logic        chg;
        logic        discharging;
        logic [7:0]  user_filtered_charge;
        logic [7:0]  fault_cause;
        logic        hibernate;
        logic [1:0]  activity;
        logic        slow;
        logic [15:0] dwell;
    } cai_state_s;

    cai_state_s  q, d;
    logic        scl_rise, scl_fall, start_c, stop_c;
    logic [15:0] clr_w, set_w, status_w, abs_cur, scaled;
    logic [7:0]  rd_w, sel_chg, bound, target, step;

    // serial pins: two flops before anything looks, third only for edges
    always_comb
    begin
        scl_rise = q.scl_s2 & ~q.scl_s3;
        scl_fall = ~q.scl_s2 & q.scl_s3;
        start_c  = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
        stop_c   = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
    end

    // status word and read mux
    always_comb
    begin
        status_w = {4'h0, q.activity, q.hibernate, q.zero, q.high, q.low, q.ut, q.ot, q.uv,
                    q.discharging, q.chg, 1'b0};
        unique case (q.ptr)
            ADR_FLAGS_HI:  rd_w = q.flags[15:8];
            ADR_FLAGS_LO:  rd_w = q.flags[7:0];
            ADR_MASK_HI:   rd_w = q.mask[15:8];
            ADR_MASK_LO:   rd_w = q.mask[7:0];
            ADR_STATUS_HI: rd_w = status_w[15:8];
            ADR_STATUS_LO: rd_w = status_w[7:0];
            ADR_USER_CHG:  rd_w = q.user_filtered_charge;
            ADR_FAULT:     rd_w = q.fault_cause;
            default:       rd_w = 8'h00;  // clear bytes and unmapped read zero
        endcase
    end

    // next state
    always_comb
    begin
        d       = q;
        clr_w   = 16'h0000;
        set_w   = 16'h0000;
        sel_chg = limits_i.use_user_charge ? q.user_filtered_charge : meas_i.relative_charge;
        bound   = (limits_i.full_scale_margin > FULL_PCT) ? 8'h00 : FULL_PCT - limits_i.full_scale_margin;
        scaled  = ({8'h00, meas_i.relative_charge} * {8'h00, FULL_PCT}) / {8'h00, bound | {7'h00, bound == 8'h00}};
        target  = (meas_i.relative_charge >= bound) ? FULL_PCT : scaled[7:0];
        step    = 8'h00;
        abs_cur = meas_i.battery_current[15] ? 16'(-meas_i.battery_current) : meas_i.battery_current;

        d.scl_s1 = scl_i;
        d.scl_s2 = q.scl_s1;
        d.scl_s3 = q.scl_s2;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.sda_s3 = q.sda_s2;

        // serial slave, bits in on scl rise, drive changes on scl fall, MSB first
        if (start_c)
        begin
            d.st     = BUS_ADDR;
            d.cnt    = 4'h0;
            d.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            d.st     = BUS_IDLE;
            d.sda_oe = 1'b0;
        end
        else if (scl_rise)
        begin
            unique case (q.st)
                BUS_ADDR, BUS_PTR, BUS_WDATA, BUS_RDATA:
                begin
                    d.shift = {q.shift[6:0], q.sda_s2};
                    d.cnt   = q.cnt + 4'h1;
                end
                BUS_RDATA_ACK: d.nack = q.sda_s2;
                BUS_IDLE, BUS_ADDR_ACK, BUS_PTR_ACK, BUS_WDATA_ACK: ;
            endcase
        end
        else if (scl_fall)
        begin
            unique case (q.st)
                BUS_IDLE: ;
                BUS_ADDR:
                    if (q.cnt == 4'h8)
                    begin
                        if (q.shift[7:1] == DEV_ADDR)
                        begin
                            d.st     = BUS_ADDR_ACK;
                            d.rw     = q.shift[0];
                            d.sda_oe = 1'b1;
                        end
                        else
                            d.st = BUS_IDLE;  // not ours, stay off the wire
                    end
                BUS_ADDR_ACK:
                begin
                    d.cnt = 4'h0;
                    if (q.rw)
                    begin
                        d.st     = BUS_RDATA;
                        d.tx     = rd_w;
                        d.ptr    = q.ptr + 8'h01;
                        d.sda_oe = ~rd_w[7];
                    end
                    else
                    begin
                        d.st     = BUS_PTR;
                        d.sda_oe = 1'b0;
                    end
                end
                BUS_PTR:
                    if (q.cnt == 4'h8)
                    begin
                        d.ptr    = q.shift;
                        d.st     = BUS_PTR_ACK;
                        d.sda_oe = 1'b1;
                    end
                BUS_WDATA:
                    if (q.cnt == 4'h8)
                    begin
                        unique case (q.ptr)
                            ADR_MASK_HI: d.mask[15:8] = q.shift;
                            ADR_MASK_LO: d.mask[7:0]  = q.shift;
                            ADR_CLR_HI:  clr_w[15:8]  = q.shift;
                            ADR_CLR_LO:  clr_w[7:0]   = q.shift;
                            default: ;  // other pointers are read only
                        endcase
                        d.ptr    = q.ptr + 8'h01;
                        d.st     = BUS_WDATA_ACK;
                        d.sda_oe = 1'b1;
                    end
                BUS_PTR_ACK, BUS_WDATA_ACK:
                begin
                    d.st     = BUS_WDATA;
                    d.cnt    = 4'h0;
                    d.sda_oe = 1'b0;
                end
                BUS_RDATA:
                    if (q.cnt == 4'h8)
                    begin
                        d.st     = BUS_RDATA_ACK;
                        d.sda_oe = 1'b0;
                    end
                    else
                        d.sda_oe = ~q.tx[3'(4'h7 - q.cnt)];
                BUS_RDATA_ACK:
                    if (q.nack)
                        d.st = BUS_IDLE;  // master is done, release
                    else
                    begin
                        d.st     = BUS_RDATA;
                        d.cnt    = 4'h0;
                        d.tx     = rd_w;
                        d.ptr    = q.ptr + 8'h01;
                        d.sda_oe = ~rd_w[7];
                    end
            endcase
        end

        // alarms only move on a fresh result while gauging runs
        if (meas_i.valid && !q.hibernate)
        begin
            d.chg         = meas_i.charger_attached;
            d.discharging = meas_i.battery_current[15];
            if (!q.uv && meas_i.averaged_cell_voltage < limits_i.undervolt_set_level)
            begin
                d.uv                = 1'b1;
                set_w[EV_UNDERVOLT] = 1'b1;
            end
            else if (q.uv && meas_i.averaged_cell_voltage > limits_i.undervolt_clear_level)
                d.uv = 1'b0;
            d.ot = $signed(meas_i.selected_temperature) > $signed(limits_i.temp_upper_bound);
            d.ut = $signed(meas_i.selected_temperature) < $signed(limits_i.temp_lower_bound);
            set_w[EV_OVERTEMP]  = d.ot & ~q.ot;
            set_w[EV_UNDERTEMP] = d.ut & ~q.ut;
            d.zero              = sel_chg == 8'h00;
            set_w[EV_EMPTY]     = d.zero & ~q.zero;
            if (d.discharging && !q.low && sel_chg <= limits_i.low_charge_level)
            begin
                d.low                = 1'b1;
                set_w[EV_LOW_ENTER]  = 1'b1;
            end
            else if (!d.discharging && q.low && sel_chg > limits_i.low_charge_level)
            begin
                d.low               = 1'b0;
                set_w[EV_LOW_EXIT]  = 1'b1;
            end
            if (!q.high && sel_chg >= limits_i.high_charge_level)
            begin
                d.high              = 1'b1;
                set_w[EV_HIGH_CHG]  = 1'b1;
            end
            else if (q.high && ({1'b0, sel_chg} + {1'b0, HIGH_HYST}) <= {1'b0, limits_i.high_charge_level})
                d.high = 1'b0;

            // user charge: slew limited, never up without a charger
            if (target > q.user_filtered_charge && meas_i.charger_attached)
            begin
                step   = (target - q.user_filtered_charge > limits_i.rise_slew_cap) ? limits_i.rise_slew_cap : target - q.user_filtered_charge;
                d.user_filtered_charge = q.user_filtered_charge + step;
            end
            else if (target < q.user_filtered_charge)
            begin
                step   = (q.user_filtered_charge - target > limits_i.fall_slew_cap) ? limits_i.fall_slew_cap : q.user_filtered_charge - target;
                d.user_filtered_charge = q.user_filtered_charge - step;
            end

            // activity: dwell counts results spent below the idle current
            if (abs_cur >= limits_i.idle_current_level)
            begin
                d.activity = ACT_ON;
                d.dwell    = 16'h0000;
            end
            else if (q.dwell >= limits_i.idle_dwell_time)
                d.activity = (abs_cur < limits_i.off_current_level) ? ACT_OFF : ACT_REST;
            else
                d.dwell = q.dwell + 16'h0001;

            // bounds fault stops gauging until resumed
            if (meas_i.bounds_fault != 8'h00)
            begin
                d.hibernate      = 1'b1;
                d.fault_cause    = meas_i.bounds_fault;
                set_w[EV_BOUNDS] = 1'b1;
            end
        end
        else if (resume_gauge_i)
            d.hibernate = 1'b0;
        d.slow = d.activity != ACT_ON;

        // outside events
        set_w[EV_STALL]     = set_w[EV_STALL] | stall_expire_i;
        set_w[EV_PACK_ERR]  = pack_link_error_i;
        set_w[EV_PULSE]     = periodic_pulse_i;
        set_w[EV_ACTIVE]    = misc_event_i[0];
        set_w[EV_MASTER]    = misc_event_i[1];
        set_w[EV_ALMOST]    = misc_event_i[2];
        set_w[EV_PACK_VOLT] = misc_event_i[3];

        // a set in the same cycle as its clear wins, so no event is lost
        d.flags   = (q.flags & ~clr_w) | set_w;
        d.int_oe  = |(q.flags & ~q.mask);
        d.int_out = 1'b0;
        d.sda_out = 1'b0;
    end

    // state register
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q          <= '0;
            q.scl_s1   <= 1'b1;
            q.scl_s2   <= 1'b1;
            q.scl_s3   <= 1'b1;
            q.sda_s1   <= 1'b1;
            q.sda_s2   <= 1'b1;
            q.sda_s3   <= 1'b1;
            q.st       <= BUS_IDLE;
            q.flags    <= RST_FLAGS;
            q.mask     <= RST_MASK;
            q.user_filtered_charge     <= RST_CHARGE;
            q.activity <= ACT_ON;
        end
        else
            q <= d;
    end

    // outputs straight from the state register
    assign sda_o                  = q.sda_out;
    assign sda_oe_o               = q.sda_oe;
    assign int_o                  = q.int_out;
    assign int_oe_o               = q.int_oe;
    assign user_filtered_charge_o = q.user_filtered_charge;
    assign gauge_activity_o       = q.activity;
    assign slow_rate_o            = q.slow;
    assign discharging_o          = q.discharging;
    assign hibernate_o            = q.hibernate;

    sequence fault_seen_s;
        meas_i.valid && !q.hibernate && meas_i.bounds_fault != 8'h00;
    endsequence
    sequence fault_taken_s;
        q.hibernate && q.flags[6] && q.fault_cause == $past(meas_i.bounds_fault);
    endsequence

    flag_sticky_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        1'b1 |=> ((($past(q.flags) & ~$past(clr_w)) & ~q.flags) == 16'h0000))
        else $error("event flag dropped without a clear");
    int_pin_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        1'b1 |=> (int_oe_o == $past(|(q.flags & ~q.mask))) && !int_o)
        else $error("interrupt pin disagrees with pending flags");
    uv_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        meas_i.valid && !q.hibernate && !q.uv && meas_i.averaged_cell_voltage < limits_i.undervolt_set_level
        |=> q.uv && q.flags[2])
        else $error("undervolt alarm not raised");
    uv_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        q.uv && !(meas_i.valid && meas_i.averaged_cell_voltage > limits_i.undervolt_clear_level) |=> q.uv)
        else $error("undervolt alarm left early");
    temp_over_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        meas_i.valid && !q.hibernate && !q.ot
        && $signed(meas_i.selected_temperature) > $signed(limits_i.temp_upper_bound) |=> q.flags[0])
        else $error("overtemperature event missing");
    high_enter_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        meas_i.valid && !q.hibernate && !q.high && sel_chg >= limits_i.high_charge_level
        |=> q.high && q.flags[3])
        else $error("high charge event missing");
    user_mono_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        meas_i.valid && !meas_i.charger_attached |=> q.user_filtered_charge <= $past(q.user_filtered_charge))
        else $error("user charge rose without charger");
    bounds_stop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        fault_seen_s |=> fault_taken_s)
        else $error("bounds fault not handled");
    activity_code_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        gauge_activity_o != 2'h0 && slow_rate_o == (gauge_activity_o != 2'h3))
        else $error("bad activity code or rate");
    stall_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        stall_expire_i |=> q.flags[12])
        else $error("stall event missing");
endmodule

/* inc/cai_pkg.sv */
// Purpose: shared constants and carriers of the charge alarm interrupt unit
// Assumes: charge values in whole percent, 0 to 100
// Notes:   serial register pointers are byte wide, upper byte of a word first
package cai_pkg;
    // serial slave address, seven bits
    localparam logic [6:0] DEV_ADDR       = 7'h38;
    // byte pointers of the serial register map
    localparam logic [7:0] ADR_FLAGS_HI   = 8'h00;
    localparam logic [7:0] ADR_FLAGS_LO   = 8'h01;
    localparam logic [7:0] ADR_MASK_HI    = 8'h02;
    localparam logic [7:0] ADR_MASK_LO    = 8'h03;
    localparam logic [7:0] ADR_CLR_HI     = 8'h04;
    localparam logic [7:0] ADR_CLR_LO     = 8'h05;
    localparam logic [7:0] ADR_STATUS_HI  = 8'h06;
    localparam logic [7:0] ADR_STATUS_LO  = 8'h07;
    localparam logic [7:0] ADR_USER_CHG   = 8'h08;
    localparam logic [7:0] ADR_FAULT      = 8'h09;
    // event bit positions
    localparam int EV_OVERTEMP   = 0;
    localparam int EV_PACK_ERR   = 1;
    localparam int EV_UNDERVOLT  = 2;
    localparam int EV_HIGH_CHG   = 3;
    localparam int EV_UNDERTEMP  = 4;
    localparam int EV_PULSE      = 5;
    localparam int EV_BOUNDS     = 6;
    localparam int EV_LOW_ENTER  = 8;
    localparam int EV_LOW_EXIT   = 9;
    localparam int EV_ACTIVE     = 10;
    localparam int EV_EMPTY      = 11;
    localparam int EV_STALL      = 12;
    localparam int EV_MASTER     = 13;
    localparam int EV_ALMOST     = 14;
    localparam int EV_PACK_VOLT  = 15;
    // activity codes, reset values, full scale and high charge hysteresis
    localparam logic [1:0]  ACT_ON        = 2'h3;
    localparam logic [1:0]  ACT_REST      = 2'h2;
    localparam logic [1:0]  ACT_OFF       = 2'h1;
    localparam logic [15:0] RST_FLAGS     = 16'h0000;
    localparam logic [15:0] RST_MASK      = 16'h0000;
    localparam logic [7:0]  RST_CHARGE    = 8'h00;
    localparam logic [7:0]  FULL_PCT      = 8'h64;
    localparam logic [7:0]  HIGH_HYST     = 8'h01;

    typedef enum logic [3:0] {BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_PTR, BUS_PTR_ACK,
                              BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RDATA_ACK} cai_bus_e;

    // programmed thresholds and setup
    typedef struct packed {
        logic [15:0] undervolt_set_level;
        logic [15:0] undervolt_clear_level;
        logic [15:0] temp_upper_bound;
        logic [15:0] temp_lower_bound;
        logic [7:0]  low_charge_level;
        logic [7:0]  high_charge_level;
        logic [7:0]  rise_slew_cap;
        logic [7:0]  fall_slew_cap;
        logic [7:0]  full_scale_margin;
        logic [15:0] idle_dwell_time;
        logic [15:0] idle_current_level;
        logic [15:0] off_current_level;
        logic        use_user_charge;
    } cai_limits_s;

    // one measurement result, valid for one cycle
    typedef struct packed {
        logic        valid;
        logic [15:0] averaged_cell_voltage;
        logic [15:0] selected_temperature;
        logic [15:0] battery_current;
        logic [7:0]  relative_charge;
        logic        charger_attached;
        logic [7:0]  bounds_fault;
    } cai_meas_s;
endpackage

/* tb/cai_host.sv */
// Purpose: serial host model, drives scl and pulls sda low
// Assumes: sda has a pull-up outside; scl high half is six core clocks, low half of a data bit is eight
// Notes:   reads end with a nack; scl never stretched by the device
`timescale 1ns/1ps
module cai_host
(
    input  wire logic core_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    import cai_pkg::*;
    logic ack_ok;
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // changes land just after an edge
    task automatic hw();
        repeat (6) @(posedge core_clk_i);
        #1;
    endtask
    // data only moves while scl is low, so no false start or stop
    task automatic bit_io(input logic b, output logic r);
        sda_low_o = !b;
        hw();
        scl_o = 1'b1;
        hw();
        r = sda_i;
        scl_o = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) // msb first
        begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(1'b1, r);
        ack_ok = ack_ok & !r;
    endtask
    // also serves as repeated start from scl low
    task automatic start();
        sda_low_o = 1'b0;
        hw(); // let the device drop its ack before scl rises, else a stray stop
        scl_o = 1'b1;
        hw();
        sda_low_o = 1'b1;
        hw();
        scl_o = 1'b0;
        hw();
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        hw();
        scl_o = 1'b1;
        hw();
        sda_low_o = 1'b0;
        hw();
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        ack_ok = 1'b1;
        start();
        xfer({DEV_ADDR, 1'b0}, q);
        xfer(p, q);
        xfer(d, q);
        stop();
        ok = ack_ok;
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] q, output logic ok);
        ack_ok = 1'b1;
        start();
        xfer({DEV_ADDR, 1'b0}, q);
        xfer(p, q);
        start();
        xfer({DEV_ADDR, 1'b1}, q);
        ok = ack_ok;
        xfer(8'hFF, q);
        stop();
    endtask
endmodule

/* tb/charge_alarm_interrupt_unit_test.sv */
// Purpose: self-checking bench of the charge alarm interrupt unit
// Assumes: 50 MHz core clock, host model on the serial pins
// Notes:   random charge values from a fixed seed
`timescale 1ns/1ps
module charge_alarm_interrupt_unit_test;
    import cai_pkg::*;
    logic        clk, rst, scl, sda_low, sda_w, sda_oe, int_oe, int_n, sda_dout, int_dout;
    logic        stall, pack, pulse, resume, slow, dis, hib, ok;
    logic [3:0]  misc;
    logic [7:0]  user_filtered_charge, q, prev, r;
    logic [1:0]  act;
    cai_meas_s   m;
    cai_limits_s lim, lim0;
    logic [159:0] rnd;
    int          num_errors, check_count, seed;
    // open-drain wires: pulled up unless some party drives low
    assign sda_w = !sda_low && (sda_oe ? sda_dout : 1'b1);
    assign int_n = int_oe ? int_dout : 1'b1;
    cai_host host_u (.core_clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
    cai_unit dut_u (.core_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_dout), .sda_oe_o(sda_oe),
        .int_o(int_dout), .int_oe_o(int_oe), .meas_i(m), .limits_i(lim), .resume_gauge_i(resume),
        .stall_expire_i(stall), .pack_link_error_i(pack), .periodic_pulse_i(pulse), .misc_event_i(misc),
        .user_filtered_charge_o(user_filtered_charge), .gauge_activity_o(act), .slow_rate_o(slow), .discharging_o(dis),
        .hibernate_o(hib));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk1(input logic g, input logic e);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t bit got %b exp %b", $time, g, e);
        end
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t byte got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] p, input logic [7:0] e);
        host_u.rd(p, q, ok);
        chk1(ok, 1'b1);
        chk8(q, e);
    endtask
    task automatic wrc(input logic [7:0] p, input logic [7:0] d);
        host_u.wr(p, d, ok);
        chk1(ok, 1'b1);
    endtask
    task automatic clr();
        wrc(ADR_CLR_HI, 8'hFF);
        wrc(ADR_CLR_LO, 8'hFF);
    endtask
    // one result, then let the one-cycle answer and pin latency land
    task automatic ms(input logic [15:0] a = 16'h0F00, t = 16'h0019, c = 16'h0010,
                      input logic [7:0] rs = 8'h32, input logic ch = 1'b1, input logic [7:0] f = 8'h00);
        @(posedge clk);
        #1;
        m = '{1'b1, a, t, c, rs, ch, f};
        @(posedge clk);
        #1;
        m.valid = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
    initial
    begin
        seed = 404;
        {rst, stall, pack, pulse, resume, misc} = '1;
        {stall, pack, pulse, resume, misc} = '0;
        m = '0;
        lim = '{16'h0C00, 16'h0D00, 16'h0040, 16'hFFF6, 8'h0A, 8'h5A, 8'h05, 8'h03, 8'h00,
                16'h0002, 16'h0000, 16'h0000, 1'b0};
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        rdc(ADR_FLAGS_LO, 8'h00);
        rdc(ADR_MASK_LO, 8'h00);
        chk1(int_n, 1'b1);
        ms();
        clr();
        ms(.a(16'h0B00));
        chk1(int_n, 1'b0);
        wrc(ADR_CLR_LO, 8'h00);
        rdc(ADR_FLAGS_LO, 8'h04);
        wrc(ADR_MASK_LO, 8'h04);
        chk1(int_n, 1'b1);
        wrc(ADR_MASK_LO, 8'h00);
        chk1(int_n, 1'b0);
        wrc(ADR_CLR_LO, 8'h04);
        chk1(int_n, 1'b1);
        ms(.a(16'h0C80));
        ms(.a(16'h0B00));
        rdc(ADR_FLAGS_LO, 8'h00);
        ms();
        ms(.a(16'h0B00));
        rdc(ADR_FLAGS_LO, 8'h04);
        clr();
        ms(.t(16'h0050));
        ms(.t(16'hFFF0));
        rdc(ADR_FLAGS_LO, 8'h11);
        clr();
        ms(.rs(8'h5F));
        rdc(ADR_FLAGS_LO, 8'h08);
        clr();
        ms(.rs(8'h5A));
        ms(.rs(8'h5F));
        rdc(ADR_FLAGS_LO, 8'h00);
        ms(.rs(8'h59));
        ms(.rs(8'h5F));
        rdc(ADR_FLAGS_LO, 8'h08);
        clr();
        ms(.c(16'hFF00), .rs(8'h0A));
        chk1(dis, 1'b1);
        ms(.c(16'hFF00), .rs(8'h00));
        ms(.rs(8'h0B));
        chk1(dis, 1'b0);
        rdc(ADR_FLAGS_HI, 8'h0B);
        clr();
        {stall, pack, pulse, misc} = '1;
        @(posedge clk);
        #1;
        {stall, pack, pulse, misc} = '0;
        rdc(ADR_FLAGS_HI, 8'hF4);
        rdc(ADR_FLAGS_LO, 8'h22);
        // rise with a charger, then random falls without one, under random limits
        lim0 = lim;
        for (int i = 0; i < 30; i++)
        begin
            prev = user_filtered_charge;
            r = 8'($unsigned($random(seed)) % 101);
            rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
            lim = rnd[152:0];
            if (i < 12)
                ms(.rs(8'h64));
            else
                ms(.c(16'hFE00), .rs(r), .ch(1'b0));
            if (i < 12)
                chk1(user_filtered_charge >= prev && user_filtered_charge - prev <= lim.rise_slew_cap, 1'b1);
            else
                chk1(user_filtered_charge <= prev && prev - user_filtered_charge <= lim.fall_slew_cap, 1'b1);
        end
        // full scale at 100 minus margin, scaled below it
        lim = lim0;
        lim.full_scale_margin = 8'h02;
        repeat (20) ms(.rs(8'h62));
        chk8(user_filtered_charge, FULL_PCT);
        repeat (17) ms(.rs(8'h31));
        chk8(user_filtered_charge, 8'h32);
        // zero alarm on user charge ignores a relative charge of zero
        clr();
        lim.use_user_charge = 1'b1;
        ms(.rs(8'h00));
        rdc(ADR_FLAGS_HI, 8'h00);
        chk1(act === ACT_ON && slow === 1'b0, 1'b1);
        lim.idle_current_level = 16'h7000;
        repeat (3) ms();
        chk1(act === ACT_REST && slow === 1'b1, 1'b1);
        lim.off_current_level = 16'h7000;
        repeat (3) ms();
        chk1(act === ACT_OFF && slow === 1'b1, 1'b1);
        clr();
        ms(.f(8'h05));
        chk1(hib, 1'b1);
        ms(.a(16'h0B00));
        rdc(ADR_FLAGS_LO, 8'h40);
        rdc(ADR_FAULT, 8'h05);
        rdc(ADR_STATUS_HI, 8'h06);
        // resume gauging, alarms move again
        resume = 1'b1;
        @(posedge clk);
        #1;
        resume = 1'b0;
        ms(.a(16'h0B00));
        chk1(hib, 1'b0);
        rdc(ADR_FLAGS_LO, 8'h44);
        rdc(8'h0A, 8'h00);
        end_of_test();
    end
endmodule
